// ---- verilog/cpwm_top.sv ----
// Module: complementary output generator core with steering and shutdown
// Operation
// RL1: Period from rising event spacing, active time from rise to fall.
// RL2: Events may share a source; inputs are sampled so any timing works.
// RL3: Phase, blanking and clocked dead band count generator clock ticks.
// RL4: Each output has its own steering enable selecting PWM or static.
// RL5: Cleared steering bit drives that output's static data bit.
// RL6: Steered mode: steering changes apply the cycle after the write.
// RL7: Synchronous steered: steering waits for next rising event, static not.
// RL8: Full bridge drives two outputs, one modulated, one at full duty.
// RL9: Direction change inserts dead band before the modulated output; code holds it off until primary next falls, no dead band.
// RL10: Forward mode: D modulated, A held on.
// RL11: Reverse mode: B modulated, C held on.
// RL12: Half bridge gives primary and complement matching input PWM.
// RL13: Half bridge turn-on waits dead band after other output turns off.
// RL14: Half bridge primary to A and/or C, complement to B and/or D.
// RL15: Push-pull: A equals C, B equals D.
// RL16: Push-pull drive rise to fall, alternating pairs each period.
// RL17: Optional blanking of opposite events after each drive edge.
// RL18: Phase delay holds the active drive after a rising event.
// RL19: Shutdown ends drive, optional auto restart, four override states.
// RL20: Each output polarity is selectable independently.
// RL21: Selected sources are ORed, each edge or level detected.
// RL22: Falling event clears primary, blanks, then complement after dead band.
// RL23: Rising event clears complement after phase, blanks, primary after dead band.
// RL24: Disabled or just enabled: primary inactive, complement active.
// RL25: Synchronous steering uses a pending latch moved on rising event.
// RL26: Reset clears steering, static data, mode and enable.
`timescale 1ns/100ps
module cpwm_top
   import cpwm_pkg::*;
#(parameter int N = CPWM_NSRC, parameter int W = CPWM_CNT_W) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_enable,
   input wire logic [2:0] i_mode,
   input wire logic i_gen_tick,
   input wire logic [N-1:0] i_rise_src,
   input wire logic [N-1:0] i_fall_src,
   input wire logic [N-1:0] i_rise_sel,
   input wire logic [N-1:0] i_fall_sel,
   input wire logic [N-1:0] i_rise_edge,
   input wire logic [N-1:0] i_fall_edge,
   input wire logic [W-1:0] i_rise_phase,
   input wire logic [W-1:0] i_fall_phase,
   input wire logic [W-1:0] i_rise_dead,
   input wire logic [W-1:0] i_fall_dead,
   input wire logic i_rise_dead_async,
   input wire logic i_fall_dead_async,
   input wire logic i_rise_dead_chain,
   input wire logic i_fall_dead_chain,
   input wire logic [W-1:0] i_rise_blank,
   input wire logic [W-1:0] i_fall_blank,
   input wire logic i_steer_wr,
   input wire logic [3:0] i_steer_enable,
   input wire logic [3:0] i_static_data,
   input wire logic [3:0] i_polarity,
   input wire logic i_shutdown,
   input wire logic i_auto_restart,
   input wire logic i_shutdown_clear,
   input wire logic [1:0] i_override_ac,
   input wire logic [1:0] i_override_bd,
   output logic [3:0] o_out,
   output logic [3:0] o_out_oe,
   output logic [3:0] o_steer_active,
   output logic o_shutdown_active
);
   logic rise_lvl, rise_ev, fall_lvl, fall_ev;
   logic rise_ok, fall_ok;
   cpwm_timer_if #(.W(W)) rph_if();
   cpwm_timer_if #(.W(W)) fph_if();
   cpwm_timer_if #(.W(W)) rdb_if();
   cpwm_timer_if #(.W(W)) fdb_if();
   cpwm_timer_if #(.W(W)) rbk_if();
   cpwm_timer_if #(.W(W)) fbk_if();

   cpwm_event_det #(.N(N)) u_rise (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_src(i_rise_src), .i_sel(i_rise_sel), .i_edge_mode(i_rise_edge),
      .o_level(rise_lvl), .o_event(rise_ev)); // [RL2] [RL21]
   cpwm_event_det #(.N(N)) u_fall (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_src(i_fall_src), .i_sel(i_fall_sel), .i_edge_mode(i_fall_edge),
      .o_level(fall_lvl), .o_event(fall_ev)); // [RL2] [RL21]
   cpwm_timer #(.W(W)) u_rph (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_tick(i_gen_tick), .tif(rph_if)); // [RL3]
   cpwm_timer #(.W(W)) u_fph (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_tick(i_gen_tick), .tif(fph_if));
   cpwm_timer #(.W(W)) u_rdb (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_tick(i_gen_tick), .tif(rdb_if));
   cpwm_timer #(.W(W)) u_fdb (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_tick(i_gen_tick), .tif(fdb_if));
   cpwm_timer #(.W(W)) u_rbk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_tick(i_gen_tick), .tif(rbk_if));
   cpwm_timer #(.W(W)) u_fbk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_tick(i_gen_tick), .tif(fbk_if));

   // Blanking: rise ignored while rising blank runs, and vice versa
   assign rise_ok = rise_ev & ~rbk_if.busy; // [RL17]
   assign fall_ok = fall_ev & ~fbk_if.busy; // [RL17]

   cpwm_edge_state_type rst_r, rst_nxt, fst_r, fst_nxt;
   logic pri_r, pri_nxt, cmp_r, cmp_nxt;
   logic [3:0] steer_r, steer_nxt, pend_r, pend_nxt, sdata_r, sdata_nxt;
   logic pend_v_r, pend_v_nxt, en_r, en_nxt, pp_r, pp_nxt;
   logic [2:0] mode_r, mode_nxt;
   logic dir_r, dir_nxt, dirchg_r, dirchg_nxt;
   logic sd_r, sd_nxt;
   logic [3:0] out_r, out_nxt, oe_r, oe_nxt;
   logic [3:0] raw, drive;
   logic rdead_done, fdead_done;

   // Clocked dead timer expiry, or delay-chain input asserted in async mode, counts as expired
   assign rdead_done = rdb_if.done | (i_rise_dead_async & i_rise_dead_chain); // [RL3]
   assign fdead_done = fdb_if.done | (i_fall_dead_async & i_fall_dead_chain); // [RL3]

   always_comb begin
      rph_if.start = rise_ok && en_r; // [RL18]
      rph_if.count = i_rise_phase;
      fph_if.start = fall_ok && en_r;
      fph_if.count = i_fall_phase;
      rbk_if.start = fall_ok && en_r; // [RL22]
      rbk_if.count = i_rise_blank;
      fbk_if.start = rise_ok && en_r; // [RL23]
      fbk_if.count = i_fall_blank;
      rdb_if.start = (rst_r == CPWM_ST_PHASE) && rph_if.done && !i_rise_dead_async;
      rdb_if.count = i_rise_dead;
      fdb_if.start = (fst_r == CPWM_ST_PHASE) && fph_if.done && !i_fall_dead_async;
      fdb_if.count = i_fall_dead;
   end

   always_comb begin
      rst_nxt = rst_r;
      fst_nxt = fst_r;
      pri_nxt = pri_r;
      cmp_nxt = cmp_r;
      pp_nxt = pp_r;
      en_nxt = i_enable;
      if (!en_r) begin
         rst_nxt = CPWM_ST_IDLE;
         fst_nxt = CPWM_ST_IDLE;
         pri_nxt = 1'b0; // [RL24]
         cmp_nxt = 1'b1; // [RL24]
      end else begin
         if (rise_ok) begin
            rst_nxt = CPWM_ST_PHASE; // [RL1]
            fst_nxt = CPWM_ST_IDLE;
            pp_nxt = ~pp_r; // [RL16]
         end else begin
            case (rst_r)
               CPWM_ST_PHASE:
                  if (rph_if.done) begin
                     cmp_nxt = 1'b0; // [RL23]
                     rst_nxt = CPWM_ST_DEAD;
                  end
               CPWM_ST_DEAD:
                  if (rdead_done) begin
                     pri_nxt = 1'b1; // [RL13] [RL23]
                     rst_nxt = CPWM_ST_ON;
                  end
               CPWM_ST_ON: rst_nxt = CPWM_ST_ON;
               default: rst_nxt = CPWM_ST_IDLE;
            endcase
         end
         if (fall_ok) begin
            pri_nxt = 1'b0; // [RL1] [RL22]
            rst_nxt = CPWM_ST_IDLE;
            fst_nxt = CPWM_ST_PHASE;
         end else begin
            case (fst_r)
               CPWM_ST_PHASE:
                  if (fph_if.done) begin
                     fst_nxt = CPWM_ST_DEAD;
                  end
               CPWM_ST_DEAD:
                  if (fdead_done) begin
                     cmp_nxt = 1'b1; // [RL13] [RL22]
                     fst_nxt = CPWM_ST_ON;
                  end
               CPWM_ST_ON: fst_nxt = CPWM_ST_ON;
               default: fst_nxt = CPWM_ST_IDLE;
            endcase
         end
      end
   end

   always_comb begin
      mode_nxt = i_mode;
      sdata_nxt = sdata_r;
      steer_nxt = steer_r;
      pend_nxt = pend_r;
      pend_v_nxt = pend_v_r;
      // Pending value moves first so a write in the same cycle stays pending
      if (pend_v_r && rise_ok) begin
         steer_nxt = pend_r; // [RL7] [RL25]
         pend_v_nxt = 1'b0;
      end
      if (i_steer_wr) begin
         sdata_nxt = i_static_data; // [RL7]
         if (mode_r == CPWM_MD_SYNC) begin
            pend_nxt = i_steer_enable; // [RL25]
            pend_v_nxt = 1'b1;
         end else begin
            steer_nxt = i_steer_enable; // [RL6]
         end
      end
      dir_nxt = dir_r;
      dirchg_nxt = dirchg_r;
      if ((mode_r == CPWM_MD_FWD) || (mode_r == CPWM_MD_REV)) begin
         dir_nxt = (mode_r == CPWM_MD_REV);
         if (dir_nxt != dir_r) begin
            dirchg_nxt = 1'b1; // [RL9]
         end else if (pri_r && !pri_nxt) begin
            dirchg_nxt = 1'b0;
         end
      end else begin
         dirchg_nxt = 1'b0;
      end
      sd_nxt = sd_r;
      if (i_shutdown) begin
         sd_nxt = 1'b1; // [RL19]
      end else if (i_auto_restart && rise_ok) begin
         sd_nxt = 1'b0; // [RL19]
      end else if (i_shutdown_clear) begin
         sd_nxt = 1'b0;
      end
   end

   always_comb begin
      raw = 4'h0;
      case (mode_r)
         CPWM_MD_STEER, CPWM_MD_SYNC: raw = {4{pri_r}}; // [RL4]
         CPWM_MD_FWD: begin
            raw[CPWM_IDX_A] = 1'b1; // [RL8] [RL10]
            raw[CPWM_IDX_D] = pri_r & ~dirchg_r; // [RL9] [RL10]
         end
         CPWM_MD_REV: begin
            raw[CPWM_IDX_C] = 1'b1; // [RL8] [RL11]
            raw[CPWM_IDX_B] = pri_r & ~dirchg_r; // [RL9] [RL11]
         end
         CPWM_MD_HALF: raw = {cmp_r, pri_r, cmp_r, pri_r}; // [RL12] [RL14]
         CPWM_MD_PP: raw = {pri_r & ~pp_r, pri_r & pp_r, pri_r & ~pp_r, pri_r & pp_r}; // [RL15]
         default: raw = 4'h0;
      endcase
      drive = raw ^ i_polarity; // [RL20]
      out_nxt = 4'h0;
      oe_nxt = 4'hF;
      for (int i = 0; i < 4; i++) begin
         if (!steer_r[i]) begin
            out_nxt[i] = sdata_r[i]; // [RL5]
         end else if (sd_r) begin
            case ((i % 2 == 0) ? i_override_ac : i_override_bd)
               CPWM_OVR_HIGH: out_nxt[i] = 1'b1;
               CPWM_OVR_LOW: out_nxt[i] = 1'b0;
               CPWM_OVR_OFF: out_nxt[i] = i_polarity[i];
               default: begin
                  out_nxt[i] = 1'b0;
                  oe_nxt[i] = 1'b0; // [RL19]
               end
            endcase
         end else if (!en_r) begin
            out_nxt[i] = ((mode_r == CPWM_MD_HALF) && (i % 2 == 1)) ^ i_polarity[i];
         end else begin
            out_nxt[i] = drive[i];
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rst_r <= CPWM_ST_IDLE;
         fst_r <= CPWM_ST_IDLE;
         pri_r <= 1'b0;
         cmp_r <= 1'b1;
         pp_r <= 1'b0;
         en_r <= 1'b0; // [RL26]
         mode_r <= CPWM_MODE_RST; // [RL26]
         steer_r <= CPWM_STEER_RST; // [RL26]
         pend_r <= CPWM_STEER_RST;
         pend_v_r <= 1'b0;
         sdata_r <= CPWM_SDATA_RST; // [RL26]
         dir_r <= 1'b0;
         dirchg_r <= 1'b0;
         sd_r <= 1'b0;
         out_r <= 4'h0;
         oe_r <= 4'hF;
      end else begin
         rst_r <= rst_nxt;
         fst_r <= fst_nxt;
         pri_r <= pri_nxt;
         cmp_r <= cmp_nxt;
         pp_r <= pp_nxt;
         en_r <= en_nxt;
         mode_r <= mode_nxt;
         steer_r <= steer_nxt;
         pend_r <= pend_nxt;
         pend_v_r <= pend_v_nxt;
         sdata_r <= sdata_nxt;
         dir_r <= dir_nxt;
         dirchg_r <= dirchg_nxt;
         sd_r <= sd_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign o_out = out_r;
   assign o_out_oe = oe_r;
   assign o_steer_active = steer_r;
   assign o_shutdown_active = sd_r;

   a_steer_static: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !steer_r[0] |=> out_r[0] == $past(sdata_r[0])) else $error("static data not driven"); // [RL5]
   a_steer_direct: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_steer_wr && mode_r == CPWM_MD_STEER |=> steer_r == $past(i_steer_enable))
      else $error("steering not applied"); // [RL6]
   a_sync_pending: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      pend_v_r && !rise_ok && !i_steer_wr |=> $stable(steer_r)) else $error("sync steer early"); // [RL7]
   a_fwd_a_on: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      mode_r == CPWM_MD_FWD && steer_r[0] && !sd_r && en_r |=> out_r[0] == ~$past(i_polarity[0]))
      else $error("forward A not on"); // [RL10]
   a_rev_c_on: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      mode_r == CPWM_MD_REV && steer_r[2] && !sd_r && en_r |=> out_r[2] == ~$past(i_polarity[2]))
      else $error("reverse C not on"); // [RL11]
   a_pp_pairs: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      mode_r == CPWM_MD_PP |-> raw[0] == raw[2] && raw[1] == raw[3]) else $error("pairs differ"); // [RL15]
   a_fall_clears: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      fall_ok && en_r |=> !pri_r) else $error("primary not cleared"); // [RL22]
   a_disabled_out: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !en_r |=> !pri_r && cmp_r) else $error("disabled state wrong"); // [RL24]
   a_shutdown_set: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_shutdown |=> sd_r) else $error("shutdown missed"); // [RL19]
   a_half_gap: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !(pri_r && cmp_r && en_r && rst_r == CPWM_ST_ON)) else $error("overlap"); // [RL13]
endmodule // cpwm_top

// ---- verilog/cpwm_pkg.sv ----
// Package: constants and types for the complementary output generator
package cpwm_pkg;
   localparam int CPWM_NSRC = 4;
   localparam int CPWM_CNT_W = 6;
   localparam logic [2:0] CPWM_MD_STEER = 3'h0;
   localparam logic [2:0] CPWM_MD_SYNC = 3'h1;
   localparam logic [2:0] CPWM_MD_FWD = 3'h2;
   localparam logic [2:0] CPWM_MD_REV = 3'h3;
   localparam logic [2:0] CPWM_MD_HALF = 3'h4;
   localparam logic [2:0] CPWM_MD_PP = 3'h5;
   localparam logic [3:0] CPWM_STEER_RST = 4'h0;
   localparam logic [3:0] CPWM_SDATA_RST = 4'h0;
   localparam logic [2:0] CPWM_MODE_RST = 3'h0;
   localparam logic [1:0] CPWM_OVR_HIGH = 2'h0;
   localparam logic [1:0] CPWM_OVR_LOW = 2'h1;
   localparam logic [1:0] CPWM_OVR_OFF = 2'h2;
   localparam logic [1:0] CPWM_OVR_HIZ = 2'h3;
   localparam int CPWM_IDX_A = 0;
   localparam int CPWM_IDX_B = 1;
   localparam int CPWM_IDX_C = 2;
   localparam int CPWM_IDX_D = 3;
   typedef enum logic [1:0] {
      CPWM_ST_IDLE = 2'h0,
      CPWM_ST_PHASE = 2'h1,
      CPWM_ST_DEAD = 2'h3,
      CPWM_ST_ON = 2'h2
   } cpwm_edge_state_type;
endpackage

// ---- verilog/cpwm_timer_if.sv ----
// Interface: start and expiry of one delay timer
`timescale 1ns/100ps
interface cpwm_timer_if #(parameter int W = 6);
   logic start;
   logic [W-1:0] count;
   logic busy;
   logic done;
   modport owner (output start, output count, input busy, input done);
   modport timer (input start, input count, output busy, output done);
endinterface // cpwm_timer_if

// ---- verilog/cpwm_timer.sv ----
// Module: down-counting delay timer on the generator clock enable
`timescale 1ns/100ps
module cpwm_timer
   import cpwm_pkg::*;
#(parameter int W = 6) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_tick,
   cpwm_timer_if.timer tif
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic busy_r;
   logic busy_nxt;
   logic done_r;
   logic done_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (tif.start) begin
         // Zero count expires at once
         cnt_nxt = tif.count;
         busy_nxt = (tif.count != '0);
         done_nxt = (tif.count == '0);
      end else if (busy_r && i_tick) begin
         cnt_nxt = cnt_r - W'(1);
         if (cnt_r == W'(1)) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         cnt_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end
   assign tif.busy = busy_r;
   assign tif.done = done_r;
endmodule // cpwm_timer

// ---- verilog/cpwm_event_det.sv ----
// Module: per-source edge or level detection and OR of selected sources
`timescale 1ns/100ps
module cpwm_event_det
   import cpwm_pkg::*;
#(parameter int N = CPWM_NSRC) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [N-1:0] i_src,
   input wire logic [N-1:0] i_sel,
   input wire logic [N-1:0] i_edge_mode,
   output logic o_level,
   output logic o_event
);
   logic [N-1:0] prev_r;
   logic [N-1:0] prev_nxt;
   logic lvl_r;
   logic lvl_nxt;
   logic [N-1:0] hit;
   always_comb begin
      prev_nxt = i_src;
      // Edge sources pulse, level sources hold
      hit = i_sel & ((i_edge_mode & i_src & ~prev_r) | (~i_edge_mode & i_src));
      lvl_nxt = |hit;
   end
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         prev_r <= '0;
         lvl_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
         lvl_r <= lvl_nxt;
      end
   end
   assign o_level = lvl_r;
   assign o_event = lvl_nxt & ~lvl_r;
endmodule // cpwm_event_det

// ---- verif/cpwm_bridge_model.sv ----
// Model of the external bridge switch drivers fed by the four outputs
`timescale 1ns/100ps
module cpwm_bridge_model (
   input wire logic i_clock,
   input wire logic [3:0] i_out,
   input wire logic [3:0] i_out_oe,
   input wire logic i_watch,
   output logic [3:0] o_pin,
   output int o_overlap
);
   logic [3:0] last_r = 4'h0;
   int overlap_r = 0;
   assign o_overlap = overlap_r;
   // Released pins show the inverse of the last level, no pull on the lines
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         o_pin[k] = i_out_oe[k] ? i_out[k] : ~last_r[k];
      end
   end
   always @(posedge i_clock) begin
      last_r <= o_pin;
      // High and low side of one leg both on is shoot-through
      if (i_watch && (&i_out_oe[1:0]) && o_pin[0] && o_pin[1]) begin
         overlap_r <= overlap_r + 1;
      end
   end
endmodule // cpwm_bridge_model

// ---- verif/cpwm_top_tb.sv ----
// Self-checking testbench of the complementary output generator
`timescale 1ns/100ps
module cpwm_top_tb;
   import cpwm_pkg::*;
   logic i_clock, i_sys_rst, en, tick, swr, sd, sar, sclr, watch, rda, rdc;
   logic [2:0] md;
   logic [3:0] rsrc, fsrc, rsel, fsel, redge, fedge, ste, sdat, pol, o_out, o_oe, o_sa, pin;
   logic [5:0] rph, fph, rdb, fdb, rbl, fbl;
   logic [1:0] oac, obd;
   logic o_sd;
   int mismatches = 0;
   int n_tests = 0;
   int overlap, n0, n1;
   cpwm_top cpwm_top_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_enable(en), .i_mode(md),
      .i_gen_tick(tick), .i_rise_src(rsrc), .i_fall_src(fsrc), .i_rise_sel(rsel),
      .i_fall_sel(fsel), .i_rise_edge(redge), .i_fall_edge(fedge), .i_rise_phase(rph),
      .i_fall_phase(fph), .i_rise_dead(rdb), .i_fall_dead(fdb), .i_rise_dead_async(rda),
      .i_fall_dead_async(rda), .i_rise_dead_chain(rdc), .i_fall_dead_chain(rdc),
      .i_rise_blank(rbl), .i_fall_blank(fbl), .i_steer_wr(swr), .i_steer_enable(ste),
      .i_static_data(sdat), .i_polarity(pol), .i_shutdown(sd), .i_auto_restart(sar),
      .i_shutdown_clear(sclr), .i_override_ac(oac), .i_override_bd(obd), .o_out(o_out),
      .o_out_oe(o_oe), .o_steer_active(o_sa), .o_shutdown_active(o_sd));
   cpwm_bridge_model cpwm_bridge_model_i (.i_clock(i_clock), .i_out(o_out), .i_out_oe(o_oe),
      .i_watch(watch), .o_pin(pin), .o_overlap(overlap));
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input bit ok, input string m);
      n_tests++;
      if (!ok) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   task wait_eq(input logic [3:0] v, output int n);
      n = 0;
      #1;
      while (o_out !== v && n < 80) begin
         @(posedge i_clock);
         #1;
         n++;
      end
      if (o_out !== v) begin
         chk(1'b0, "output never reached expected level");
         end_of_test();
      end
   endtask
   task rise_ev;
      @(posedge i_clock) rsrc <= 4'h1;
      step(3);
      rsrc <= 4'h0;
   endtask
   task fall_ev;
      @(posedge i_clock) fsrc <= 4'h2;
      step(3);
      fsrc <= 4'h0;
   endtask
   task wr_steer(input logic [3:0] s, input logic [3:0] d);
      @(posedge i_clock) swr <= 1'b1;
      ste <= s;
      sdat <= d;
      @(posedge i_clock) swr <= 1'b0;
      step(2);
      #1;
   endtask
   task t_static;
      wr_steer(4'h0, 4'hA);
      chk(o_out === 4'hA, "static data A");
      wr_steer(4'h0, 4'h5);
      chk(o_out === 4'h5, "static data 5");
      $display("test static done");
   endtask
   task t_steer;
      @(posedge i_clock) en <= 1'b1;
      wr_steer(4'h5, 4'h0);
      chk(o_sa === 4'h5, "steering applied after write");
      rise_ev();
      wait_eq(4'h5, n0);
      fall_ev();
      wait_eq(4'h0, n0);
      rise_ev();
      wait_eq(4'h5, n0);
      fall_ev();
      wait_eq(4'h0, n0);
      rph <= 6'h08;
      rise_ev();
      wait_eq(4'h5, n1);
      chk(n1 >= n0 + 7, "phase delay holds drive");
      rph <= 6'h00;
      fall_ev();
      wait_eq(4'h0, n0);
      $display("test steer done");
   endtask
   task t_blank;
      fbl <= 6'h14;
      rise_ev();
      wait_eq(4'h5, n0);
      fall_ev();
      step(6);
      #1;
      chk(o_out === 4'h5, "falling event blanked");
      fbl <= 6'h00;
      step(24);
      fall_ev();
      wait_eq(4'h0, n0);
      $display("test blank done");
   endtask
   task t_sync;
      @(posedge i_clock) md <= CPWM_MD_SYNC;
      wr_steer(4'hF, 4'h0);
      step(4);
      #1;
      chk(o_sa === 4'h5, "sync steering waits");
      rise_ev();
      step(4);
      #1;
      chk(o_sa === 4'hF, "sync steering on rise");
      fall_ev();
      wait_eq(4'h0, n0);
      $display("test sync done");
   endtask
   task t_bridge;
      @(posedge i_clock) md <= CPWM_MD_FWD;
      repeat (2) begin
         rise_ev();
         step(20);
         fall_ev();
         step(20);
      end
      #1;
      chk(o_out === 4'h1, "forward idle A on");
      rise_ev();
      wait_eq(4'h9, n0);
      fall_ev();
      wait_eq(4'h1, n0);
      @(posedge i_clock) md <= CPWM_MD_REV;
      rise_ev();
      step(12);
      #1;
      chk(o_out === 4'h4, "modulated held off on reversal");
      fall_ev();
      step(20);
      rise_ev();
      wait_eq(4'h6, n0);
      fall_ev();
      wait_eq(4'h4, n0);
      $display("test bridge done");
   endtask
   task t_half;
      @(posedge i_clock) en <= 1'b0;
      md <= CPWM_MD_HALF;
      step(3);
      #1;
      chk(o_out === 4'hA, "disabled complement active");
      @(posedge i_clock) en <= 1'b1;
      step(2);
      #1;
      chk(o_out === 4'hA, "just enabled complement active");
      rdb <= 6'h04;
      fdb <= 6'h04;
      n1 = overlap;
      watch <= 1'b1;
      repeat (2) begin
         rise_ev();
         wait_eq(4'h5, n0);
         chk(n0 >= 4, "dead band delays turn-on");
         fall_ev();
         wait_eq(4'hA, n0);
      end
      watch <= 1'b0;
      chk(overlap === n1, "no overlap of one leg");
      wr_steer(4'h3, 4'h0);
      rise_ev();
      wait_eq(4'h1, n0);
      fall_ev();
      wait_eq(4'h2, n0);
      rdb <= 6'h00;
      fdb <= 6'h00;
      $display("test half done");
   endtask
   task t_chain;
      @(posedge i_clock) rda <= 1'b1;
      rdc <= 1'b0;
      rise_ev();
      step(8);
      #1;
      chk(o_out === 4'h0, "turn-on waits for delay chain");
      @(posedge i_clock) rdc <= 1'b1;
      wait_eq(4'h1, n0);
      fall_ev();
      wait_eq(4'h2, n0);
      @(posedge i_clock) rda <= 1'b0;
      rdc <= 1'b0;
      rph <= 6'h03;
      tick <= 1'b0;
      rise_ev();
      step(8);
      #1;
      chk(o_out === 4'h2, "phase counts only on ticks");
      @(posedge i_clock) tick <= 1'b1;
      wait_eq(4'h1, n0);
      @(posedge i_clock) rph <= 6'h00;
      fall_ev();
      wait_eq(4'h2, n0);
      $display("test chain done");
   endtask
   task t_push;
      logic [3:0] p;
      @(posedge i_clock) md <= CPWM_MD_PP;
      wr_steer(4'hF, 4'h0);
      rise_ev();
      step(12);
      #1;
      p = o_out;
      chk(p === 4'h5 || p === 4'hA, "push-pull pairs match");
      fall_ev();
      wait_eq(4'h0, n0);
      rise_ev();
      wait_eq(~p, n0);
      fall_ev();
      wait_eq(4'h0, n0);
      $display("test push done");
   endtask
   task t_shut;
      @(posedge i_clock) md <= CPWM_MD_STEER;
      pol <= 4'h3;
      for (int c = 0; c < 4; c++) begin
         @(posedge i_clock) oac <= c[1:0];
         obd <= c[1:0];
         sd <= 1'b1;
         step(4);
         #1;
         chk(o_sd === 1'b1, "shutdown active");
         if (c == 3) begin
            chk(o_oe === 4'h0, "override high impedance");
         end else begin
            chk(o_oe === 4'hF && o_out === ((c == 0) ? 4'hF : (c == 1) ? 4'h0 : 4'h3),
               "override level");
         end
         @(posedge i_clock) sd <= 1'b0;
         sclr <= 1'b1;
         @(posedge i_clock) sclr <= 1'b0;
         step(3);
         #1;
         chk(o_sd === 1'b0, "shutdown cleared");
      end
      @(posedge i_clock) sar <= 1'b1;
      sd <= 1'b1;
      @(posedge i_clock) sd <= 1'b0;
      step(2);
      #1;
      chk(o_sd === 1'b1, "shutdown held until restart");
      rise_ev();
      #1;
      chk(o_sd === 1'b0, "auto restart on rising event");
      @(posedge i_clock) sar <= 1'b0;
      $display("test shutdown done");
   endtask
   initial begin
      {en, swr, sd, sar, sclr, watch, rda, rdc} = 8'h00;
      tick = 1'b1;
      md = CPWM_MD_STEER;
      {rsrc, fsrc, ste, sdat, pol} = 20'h00000;
      rsel = 4'h1;
      fsel = 4'h2;
      redge = 4'hF;
      fedge = 4'hF;
      {rph, fph, rdb, fdb, rbl, fbl} = 36'h000000000;
      {oac, obd} = 4'h0;
      i_sys_rst = 1'b1;
      step(5);
      i_sys_rst <= 1'b0;
      #1;
      chk(o_out === 4'h0 && o_oe === 4'hF && o_sa === 4'h0 && o_sd === 1'b0,
         "reset state");
      t_static();
      t_steer();
      t_blank();
      t_sync();
      t_bridge();
      t_half();
      t_chain();
      t_push();
      t_shut();
      end_of_test();
   end
endmodule // cpwm_top_tb
